// [include/vpw_defines.svh]
// Constants of the variable-pulse-width link protocol handler.
// Assumes a 20 MHz pclk; symbol timing runs on a 1 us tick.
`ifndef VPW_DEFINES_SVH
`define VPW_DEFINES_SVH

// =============================================
// Timing
`define PCLK_NS      50
`define TICK_NS      1000
`define TICK_CYC     (`TICK_NS / `PCLK_NS)
// Receive windows, in us at normal rate
`define RX_MIN_US    9'h022
`define RX_SHORT_US  9'h060
`define RX_LONG_US   9'h0A3
`define RX_SOF_US    9'h0EF
`define RX_EOF_US    9'h118
`define RX_IDLE_US   9'h12C
`define RX_BREAK_US  9'h0F0
// Transmit symbol widths, in us
`define TX_SHORT_US  8'h40
`define TX_LONG_US   8'h80
`define TX_SOF_US    8'hC8
`define TX_EOD_US    8'hC8
`define TX_SETTLE_US 8'h0C

// =============================================
// Register map, byte addresses
`define OFS_CTRL1    8'h00
`define OFS_CTRL2    8'h04
`define OFS_STATE    8'h08
`define OFS_DATA     8'h0C
`define IE_BIT       0
`define DIGITAL_LOOPBACK_BIT_BIT    0
`define FAST_BIT     1

// =============================================
// State vector codes
`define SV_NONE      8'h00
`define SV_EOF       8'h04
`define SV_IFR       8'h08
`define SV_RXF       8'h0C
`define SV_TXE       8'h10
`define SV_LOA       8'h14
`define SV_CRC       8'h18
`define SV_INV       8'h1C

// =============================================
// CRC-8
`define CRC_INIT     8'hFF
`define CRC_POLY     8'h1D
`define CRC_RESIDUE  8'hC4

`endif

// [include/vpw_pkg.sv]
// Types shared by the protocol handler and its helpers.
// Assumes vpw_defines.svh is on the include path.
`include "vpw_defines.svh"

package vpw_pkg;

  typedef enum logic [3:0] {
    SYM_NONE, SYM_BIT0, SYM_BIT1, SYM_SOF, SYM_EOD,
    SYM_EOF, SYM_IDLE, SYM_BREAK, SYM_BAD
  } sym_e;

  typedef struct packed {
    logic vld;
    sym_e kind;
  } sym_s;

  typedef enum logic [1:0] {RX_HUNT, RX_DATA, RX_WAIT_EOF, RX_WAIT_IDLE} rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_SOF, TX_BITS, TX_EOD} tx_e;

  typedef struct packed {
    logic inv;
    logic crc;
    logic arbitration_lost_flag;
    logic txe;
    logic rxf;
    logic ifr;
    logic eof;
  } flags_s;

  typedef struct packed {
    logic       prev;
    logic [8:0] cnt;
    logic [1:0] stage;
    sym_s       sym;
  } tm_s;

  typedef struct packed {
    logic a;
    logic b;
  } sy_s;

  typedef struct packed {
    logic [4:0]  pre;
    logic        tick;
    logic        ie;
    logic        digital_loopback_bit;
    logic        fast;
    rx_e         rs;
    logic [2:0]  rbits;
    logic [7:0]  rsh;
    logic [7:0]  rhold;
    logic [7:0]  rcrc;
    logic        ifr_mode;
    logic        nb;
    logic        eof_ok;
    tx_e         ts;
    logic [7:0]  tsh;
    logic [7:0]  thold;
    logic        tpend;
    logic [7:0]  tcrc;
    logic        crc_sent;
    logic [2:0]  tbits;
    logic [7:0]  tcnt;
    logic [7:0]  twid;
    logic        txo;
    logic        pin;
    flags_s      fl;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
  } hs_s;

  // MSB-first CRC-8 over one byte
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
    begin
      r = r[7] ? ({r[6:0], 1'b0} ^ `CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

endpackage

// [design/vpw_sync2.sv]
// Two-flop synchroniser for the receive pin.
// Assumes the pin is asynchronous to pclk.
`timescale 1ns/1ps

module vpw_sync2 import vpw_pkg::*;
(
  input  logic pclk,     // module clock
  input  logic presetn,  // async reset, low
  input  logic ce,       // clock enable
  input  logic din,      // asynchronous level
  output logic dout      // synchronised level
);

  sy_s q;
  sy_s d;

  always_comb
  begin
    d = q;
    if (ce)
    begin
      d.a = din;
      d.b = q.a;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign dout = q.b;

endmodule

// [design/vpw_symbol_timer.sv]
// Measures each level on the internal receive line and names the symbol.
// Assumes a one-cycle 1 us tick and a line already in the pclk domain.
`timescale 1ns/1ps

module vpw_symbol_timer import vpw_pkg::*;
(
  input  logic pclk,     // module clock
  input  logic presetn,  // async reset, low
  input  logic ce,       // clock enable
  input  logic tick,     // 1 us strobe
  input  logic line,     // receive level, high = active
  input  logic fast,     // 4X receive windows
  output sym_s sym       // symbol strobe and kind
);

  tm_s q;
  tm_s d;

  // Fast windows other than break are a quarter wide
  function automatic logic [8:0] sc(input logic [8:0] us, input logic f);
    return f ? {2'b00, us[8:2]} : us;
  endfunction

  function automatic sym_e pas_kind(input logic [8:0] c, input logic f);
    if (c < sc(`RX_MIN_US, f))
      return SYM_BAD;
    else if (c < sc(`RX_SHORT_US, f))
      return SYM_BIT0;
    else if (c < sc(`RX_LONG_US, f))
      return SYM_BIT1;
    else if (c < sc(`RX_SOF_US, f))
      return SYM_EOD;
    else
      return SYM_EOF;
  endfunction

  function automatic sym_e act_kind(input logic [8:0] c, input logic f);
    if (c < sc(`RX_MIN_US, f))
      return SYM_BAD;
    else if (c < sc(`RX_SHORT_US, f))
      return SYM_BIT1;
    else if (c < sc(`RX_LONG_US, f))
      return SYM_BIT0;
    else if (c < sc(`RX_SOF_US, f))
      return SYM_SOF;
    else
      return SYM_BAD;
  endfunction

  always_comb
  begin
    d = q;
    d.sym.vld = 1'b0;
    d.sym.kind = SYM_NONE;
    if (line != q.prev)
    begin
      d.prev = line;
      d.cnt = '0;
      d.stage = 2'h0;
      // A level already named by timeout ends silently
      if (q.stage == 2'h0)
      begin
        d.sym.vld = 1'b1;
        d.sym.kind = q.prev ? act_kind(q.cnt, fast) : pas_kind(q.cnt, fast);
      end
    end
    else if (tick)
    begin
      if (q.cnt != 9'h1FF)
        d.cnt = q.cnt + 9'h001;
      if (!q.prev && q.stage == 2'h0 && d.cnt == sc(`RX_EOF_US, fast))
      begin
        d.sym.vld = 1'b1;
        d.sym.kind = SYM_EOF;
        d.stage = 2'h1;
      end
      else if (!q.prev && q.stage == 2'h1 && d.cnt == sc(`RX_IDLE_US, fast))
      begin
        d.sym.vld = 1'b1;
        d.sym.kind = SYM_IDLE;
        d.stage = 2'h2;
      end
      else if (q.prev && q.stage == 2'h0 && d.cnt == `RX_BREAK_US)
      begin
        d.sym.vld = 1'b1;
        d.sym.kind = SYM_BREAK;
        d.stage = 2'h2;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign sym = q.sym;

endmodule

// [design/vpw_serial_protocol_handler.sv]
// Protocol handler of a single-wire variable-pulse-width link:
// holding registers, loopback mux, framing, CRC and bus error handling.
// Assumes an APB master on pclk and an external transceiver on the pins.
`timescale 1ns/1ps

module vpw_serial_protocol_handler import vpw_pkg::*;
(
  input  logic        pclk,          // module clock, 20 MHz
  input  logic        presetn,       // async reset, low
  input  logic        ce,            // clock enable, freezes all
  input  logic        psel,          // APB select
  input  logic        penable,       // APB enable
  input  logic        pwrite,        // APB direction
  input  logic [7:0]  paddr,         // APB byte address
  input  logic [31:0] pwdata,        // APB write data
  output logic [31:0] prdata,        // APB read data
  output logic        pready,        // APB ready
  output logic        pslverr,       // APB error
  input  logic        rx_input_pin,  // bus level, high = active
  output logic        tx_output_pin, // drive active when high
  output logic        irq            // interrupt request, high
);

  hs_s  q;
  hs_s  d;
  logic rx_s;
  logic rx_int;
  sym_s sym;
  logic acc;
  logic wr;
  logic rd;
  logic busy;
  logic [7:0] code;

  // =============================================
  // Helpers
  function automatic logic [7:0] bit_us(input logic b, input logic act);
    return (b ^ act) ? `TX_LONG_US : `TX_SHORT_US;
  endfunction

  function automatic logic [7:0] sv_code(input flags_s f, input logic bz);
    if (f.inv)
      return `SV_INV;
    else if (f.crc)
      return `SV_CRC;
    else if (f.arbitration_lost_flag)
      return `SV_LOA;
    else if (f.txe && bz)
      return `SV_TXE;
    else if (f.rxf)
      return `SV_RXF;
    else if (f.ifr)
      return `SV_IFR;
    else if (f.eof)
      return `SV_EOF;
    else
      return `SV_NONE;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a == `OFS_CTRL1 || a == `OFS_CTRL2 || a == `OFS_STATE || a == `OFS_DATA;
  endfunction

  // =============================================
  // Pin input and loopback
  vpw_sync2 u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (rx_input_pin),
    .dout    (rx_s)
  );

  assign rx_int = q.digital_loopback_bit ? q.txo : rx_s;

  vpw_symbol_timer u_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .tick    (q.tick),
    .line    (rx_int),
    .fast    (q.fast),
    .sym     (sym)
  );

  assign busy = q.ts != TX_IDLE;
  assign code = sv_code(q.fl, busy);
  assign acc  = psel && penable && q.pready;
  assign wr   = acc && pwrite;
  assign rd   = acc && !pwrite;

  // =============================================
  // Next state
  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (q.pre == 5'(`TICK_CYC - 1))
    begin
      d.pre = 5'h00;
      d.tick = 1'b1;
    end
    else
      d.pre = q.pre + 5'h01;

    // Zero-wait APB: answer prepared in the setup cycle
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    if (psel && !penable && !q.pready)
    begin
      d.pready = 1'b1;
      d.pslverr = !addr_ok(paddr);
      case (paddr)
        `OFS_CTRL1: d.prdata = {31'h0, q.ie};
        `OFS_CTRL2: d.prdata = {30'h0, q.fast, q.digital_loopback_bit};
        `OFS_STATE: d.prdata = {24'h0, code};
        `OFS_DATA:  d.prdata = {24'h0, q.rhold};
        default:    d.prdata = 32'h0;
      endcase
    end

    // Software clears first so hardware sets below win
    if (wr && paddr == `OFS_CTRL1)
      d.ie = pwdata[`IE_BIT];
    if (wr && paddr == `OFS_CTRL2)
    begin
      d.digital_loopback_bit = pwdata[`DIGITAL_LOOPBACK_BIT_BIT];
      d.fast = pwdata[`FAST_BIT];
    end
    if (wr && paddr == `OFS_DATA)
    begin
      d.thold = pwdata[7:0];
      d.tpend = 1'b1;
      d.fl.txe = 1'b0;
    end
    if (rd && paddr == `OFS_DATA)
    begin
      d.fl.rxf = 1'b0;
      d.fl.ifr = 1'b0;
    end
    if (rd && paddr == `OFS_STATE)
    begin
      case (code)
        `SV_INV: d.fl.inv = 1'b0;
        `SV_CRC: d.fl.crc = 1'b0;
        `SV_LOA: d.fl.arbitration_lost_flag = 1'b0;
        `SV_EOF: d.fl.eof = 1'b0;
        default: d.fl = d.fl;
      endcase
    end

    // =============================================
    // Transmitter, timed in 1 us ticks
    // no break symbol state exists
    if (q.tick)
    begin
      case (q.ts)
        TX_IDLE:
        begin
          d.txo = 1'b0;
          // start only after end of frame
          if (q.tpend && !q.fast && q.eof_ok && q.rs == RX_HUNT && !rx_int)
          begin
            d.ts = TX_SOF;
            d.txo = 1'b1;
            d.tcnt = 8'h00;
            d.twid = `TX_SOF_US;
            d.tsh = q.thold;
            d.tcrc = crc8(`CRC_INIT, q.thold);
            d.tpend = 1'b0;
            d.fl.txe = 1'b1;
            d.crc_sent = 1'b0;
            d.tbits = 3'h0;
          end
        end
        TX_SOF, TX_BITS, TX_EOD:
        begin
          d.tcnt = q.tcnt + 8'h01;
          if (q.tcnt >= `TX_SETTLE_US && rx_int != q.txo)
          begin
            d.ts = TX_IDLE;
            d.txo = 1'b0;
            if (q.txo)
            begin
              d.fl.inv = 1'b1;
              d.tpend = 1'b0;
            end
            else if (q.ts == TX_EOD)
              // active seen during end of data
              d.fl.inv = 1'b1;
            else
              d.fl.arbitration_lost_flag = 1'b1;
          end
          else if (d.tcnt == q.twid)
          begin
            d.tcnt = 8'h00;
            if (q.ts == TX_SOF)
            begin
              d.ts = TX_BITS;
              d.txo = 1'b0;
              d.twid = bit_us(q.tsh[7], 1'b0);
            end
            else if (q.ts == TX_EOD)
              d.ts = TX_IDLE;
            else
            begin
              d.tbits = q.tbits + 3'h1;
              d.tsh = {q.tsh[6:0], 1'b0};
              if (q.tbits == 3'h7)
              begin
                if (q.tpend)
                begin
                  d.tsh = q.thold;
                  d.tcrc = crc8(q.tcrc, q.thold);
                  d.tpend = 1'b0;
                  d.fl.txe = 1'b1;
                end
                else if (!q.crc_sent)
                begin
                  d.tsh = ~q.tcrc;
                  d.crc_sent = 1'b1;
                end
                else
                  d.ts = TX_EOD;
              end
              d.txo = !q.txo;
              if (d.ts == TX_EOD)
              begin
                d.txo = 1'b0;
                d.twid = `TX_EOD_US;
              end
              else
                d.twid = bit_us(d.tsh[7], d.txo);
            end
          end
        end
        default: d.ts = TX_IDLE;
      endcase
    end

    // =============================================
    // Receiver, driven by classified symbols
    if (sym.vld)
    begin
      if (sym.kind == SYM_BREAK)
      begin
        d.fl.inv = 1'b1;
        d.rs = RX_WAIT_IDLE;
        d.ts = TX_IDLE;
        d.txo = 1'b0;
        d.eof_ok = 1'b0;
        d.fast = 1'b0;
      end
      else if (sym.kind == SYM_EOF || sym.kind == SYM_IDLE)
        d.eof_ok = 1'b1;
      else
        d.eof_ok = 1'b0;

      case (q.rs)
        RX_HUNT:
          // anything but a break before a start is ignored
          if (sym.kind == SYM_SOF)
          begin
            d.rs = RX_DATA;
            d.rbits = 3'h0;
            d.rcrc = `CRC_INIT;
            d.ifr_mode = 1'b0;
            d.nb = 1'b0;
          end
        RX_DATA:
          case (sym.kind)
            SYM_BIT0, SYM_BIT1:
              if (q.nb)
                d.nb = 1'b0;
              else
              begin
                // no byte limit in a frame
                d.rsh = {q.rsh[6:0], sym.kind == SYM_BIT1};
                d.rbits = q.rbits + 3'h1;
                if (q.rbits == 3'h7)
                begin
                  d.rhold = d.rsh;
                  d.rcrc = crc8(q.rcrc, d.rsh);
                  if (q.ifr_mode)
                    d.fl.ifr = 1'b1;
                  else
                    d.fl.rxf = 1'b1;
                end
              end
            SYM_EOD:
              if (q.rbits != 3'h0)
              begin
                // end of data off byte boundary
                d.fl.inv = 1'b1;
                d.rs = RX_WAIT_EOF;
              end
              else if (!q.ifr_mode && q.rcrc != `CRC_RESIDUE)
              begin
                d.fl.crc = 1'b1;
                d.rs = RX_WAIT_EOF;
              end
              else
              begin
                d.ifr_mode = 1'b1;
                d.nb = 1'b1;
                d.rcrc = `CRC_INIT;
              end
            SYM_EOF, SYM_IDLE:
            begin
              if (q.rbits != 3'h0)
                // end of frame off byte boundary
                d.fl.inv = 1'b1;
              // END_OF_DATA_SYMBOL runs into EOF with no edge, so check here
              // CRC mismatch at frame end
              else if (!q.ifr_mode && q.rcrc != `CRC_RESIDUE)
                d.fl.crc = 1'b1;
              else
                d.fl.eof = 1'b1;
              d.rs = RX_HUNT;
            end
            SYM_BREAK: d.rs = RX_WAIT_IDLE;
            default:
            begin
              d.fl.inv = 1'b1;
              d.rs = RX_WAIT_EOF;
            end
          endcase
        RX_WAIT_EOF:
          if (sym.kind == SYM_EOF || sym.kind == SYM_IDLE)
            d.rs = RX_HUNT;
          else if (sym.kind == SYM_BREAK)
            d.rs = RX_WAIT_IDLE;
        RX_WAIT_IDLE:
          // resume once the bus is idle
          if (sym.kind == SYM_IDLE)
            d.rs = RX_HUNT;
        default: d.rs = RX_HUNT;
      endcase
    end

    // Loopback keeps the real bus passive
    // detach drive in loopback
    d.pin = d.txo && !d.digital_loopback_bit;
    d.irq = d.ie && (sv_code(d.fl, d.ts != TX_IDLE) != `SV_NONE);
  end

  // =============================================
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.fl.txe <= 1'b1;
    end
    else if (ce)
      q <= d;
  end

  assign prdata        = q.prdata;
  assign pready        = q.pready;
  assign pslverr       = q.pslverr;
  assign tx_output_pin = q.pin;
  assign irq           = q.irq;

endmodule

// [sim/vpw_serial_protocol_handler_assertions.sv]
// Checker: APB answer, irq gating, loopback and drive-line timing.
// Assumes one pclk domain; bound to the handler's top module.
`timescale 1ns/1ps
`include "vpw_defines.svh"

module vpw_serial_protocol_handler_assertions import vpw_pkg::*;
(
  input logic        pclk,          // clock
  input logic        presetn,       // reset, low
  input logic        ce,            // clock enable
  input logic        psel,          // APB select
  input logic        penable,       // APB enable
  input logic        pwrite,        // APB write
  input logic [7:0]  paddr,         // APB address
  input logic [31:0] pwdata,        // APB data
  input logic [31:0] prdata,        // APB read data
  input logic        pready,        // APB ready
  input logic        pslverr,       // APB error
  input logic        rx_input_pin,  // bus level
  input logic        tx_output_pin, // drive
  input logic        irq            // interrupt
);
  // =========================================
  // Control shadows and level counters
  logic        ie_q, digital_loopback_bit_q, fast_q;
  logic [15:0] txh_q, act_q, mis_q;
  logic        wr;

  assign wr = psel && penable && pready && pwrite;

  // Fast shadow goes stale on a break; bench rewrites the bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ie_q    <= 1'b0;
      digital_loopback_bit_q <= 1'b0;
      fast_q  <= 1'b0;
      txh_q   <= 16'h0000;
      act_q   <= 16'h0000;
      mis_q   <= 16'h0000;
    end
    else
    begin
      if (wr && paddr == `OFS_CTRL1)
        ie_q <= pwdata[`IE_BIT];
      if (wr && paddr == `OFS_CTRL2)
      begin
        digital_loopback_bit_q <= pwdata[`DIGITAL_LOOPBACK_BIT_BIT];
        fast_q  <= pwdata[`FAST_BIT];
      end
      txh_q <= tx_output_pin ? txh_q + 16'h0001 : 16'h0000;
      act_q <= rx_input_pin ? act_q + 16'h0001 : 16'h0000;
      mis_q <= (tx_output_pin && !rx_input_pin) ? mis_q + 16'h0001 : 16'h0000;
    end
  end

  // =========================================
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_rdy;
    (psel && !penable && ce) ##1 ce |-> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_only;
    pready |-> psel && penable;
  endproperty
  a_only: assert property (p_only) else $error("ready outside access");
  property p_err;
    pready |-> (pslverr == !(paddr inside {`OFS_CTRL1, `OFS_CTRL2, `OFS_STATE, `OFS_DATA}));
  endproperty
  a_err: assert property (p_err) else $error("error flag wrong for address");
  property p_ie;
    !ie_q && !$past(ie_q) |-> !irq;
  endproperty
  a_ie: assert property (p_ie) else $error("irq while disabled");
  property p_loop;
    digital_loopback_bit_q && $past(digital_loopback_bit_q) |-> !tx_output_pin;
  endproperty
  a_loop: assert property (p_loop) else $error("bus driven in loopback");
  property p_fast;
    $rose(tx_output_pin) |-> !fast_q;
  endproperty
  a_fast: assert property (p_fast) else $error("transmit in fast mode");
  property p_stuck;
    $rose(tx_output_pin) |-> act_q < 16'h0064;
  endproperty
  a_stuck: assert property (p_stuck) else $error("transmit on active bus");
  property p_brk;
    txh_q < 16'h12C0;
  endproperty
  a_brk: assert property (p_brk) else $error("drive held as long as break");
  property p_gnd;
    mis_q < 16'h0190;
  endproperty
  a_gnd: assert property (p_gnd) else $error("drive kept on undrivable bus");
endmodule

bind vpw_serial_protocol_handler vpw_serial_protocol_handler_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_input_pin(rx_input_pin), .tx_output_pin(tx_output_pin),
  .irq(irq));

// [sim/vpw_bus_node.sv]
// Model of the other nodes on the single-wire bus.
// Assumes a wired bus, active high, and 20 pclk per microsecond.
`timescale 1ns/1ps
`include "vpw_defines.svh"

module vpw_bus_node
(
  input  logic pclk, // bench clock
  input  logic tx,   // device drive
  output logic bus   // level seen by device
);
  logic drv = 1'b0;
  logic gnd = 1'b0;
  int   edges = 0;

  // A ground short keeps the device from pulling the bus active
  assign bus = (tx && !gnd) || drv;

  always @(posedge tx) edges++;

  task automatic hold(input logic a, input int n);
    drv <= a;
    repeat (n) @(posedge pclk);
  endtask

  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'b0} ^ `CRC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction

  // =========================================
  // Frame: SOF, nb bytes, CRC, then passive; d divides widths
  task automatic frame(input logic [15:0] b, input int nb, input int d, input logic bad);
    logic [7:0]  c;
    logic [23:0] s;
    c = crc(`CRC_INIT, b[15:8]);
    if (nb == 2)
      c = crc(c, b[7:0]);
    c = ~c ^ {7'h00, bad};
    s = (nb == 2) ? {b, c} : {b[15:8], c, 8'h00};
    hold(1'b1, 4000 / d);
    for (int k = 0; k < 8 * (nb + 1); k++)
      hold(k[0], (s[23 - k] == k[0]) ? 1280 / d : 2560 / d);
    hold(1'b0, 6400 / d);
  endtask
endmodule

// [sim/vpw_serial_protocol_handler_tb.sv]
// Self-checking bench: APB master tasks, one task per scenario.
// Assumes the bus node model on the pin and a 20 MHz pclk.
`timescale 1ns/1ps
`include "vpw_defines.svh"

module vpw_serial_protocol_handler_tb import vpw_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, tx, bus, irq;
  int          errors = 0;
  int          compares = 0;

  vpw_serial_protocol_handler i_dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_input_pin(bus), .tx_output_pin(tx), .irq(irq));
  vpw_bus_node i_node (.pclk(pclk), .tx(tx), .bus(bus));

  always #25 pclk = ~pclk;

  // =========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic drain();
    repeat (4) apb(1'b0, `OFS_STATE, 32'h0);
  endtask

  task automatic wait_tx(input logic lvl, input int n);
    int i;
    i = 0;
    while (tx !== lvl && i < n)
    begin
      @(posedge pclk);
      i++;
    end
    chk({31'h0, tx}, {31'h0, lvl});
  endtask

  task automatic report_and_stop();
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // =========================================
  // Scenarios
  task automatic t_regs();
    rdc(`OFS_CTRL1, 32'h0);
    rdc(`OFS_CTRL2, 32'h0);
    apb(1'b1, `OFS_STATE, 32'hFF);
    rdc(`OFS_STATE, 32'h0);
    rdc(8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, `OFS_CTRL2, 32'h1);
    rdc(`OFS_CTRL2, 32'h1);
    apb(1'b1, `OFS_CTRL2, 32'h0);
  endtask

  task automatic t_rx_good();
    apb(1'b1, `OFS_CTRL2, 32'h2);
    i_node.frame(16'h3C5A, 2, 4, 1'b0);
    rdc(`OFS_STATE, {24'h0, `SV_RXF});
    chk({31'h0, irq}, 32'h0);
    rdc(`OFS_DATA, {24'h0, ~i_node.crc(i_node.crc(`CRC_INIT, 8'h3C), 8'h5A)});
    rdc(`OFS_STATE, {24'h0, `SV_EOF});
  endtask

  task automatic t_rx_crc();
    apb(1'b1, `OFS_CTRL1, 32'h1);
    i_node.frame(16'h3C00, 1, 4, 1'b1);
    chk({31'h0, irq}, 32'h1);
    rdc(`OFS_STATE, {24'h0, `SV_CRC});
    rdc(`OFS_DATA, {24'h0, ~i_node.crc(`CRC_INIT, 8'h3C) ^ 8'h01});
    apb(1'b1, `OFS_CTRL1, 32'h0);
    drain();
  endtask

  task automatic t_noise();
    apb(1'b1, `OFS_CTRL2, 32'h0);
    i_node.frame(16'h3C00, 1, 4, 1'b0);
    apb(1'b0, `OFS_STATE, 32'h0);
    chk({31'h0, rd[7:0] === `SV_RXF}, 32'h0);
    drain();
  endtask

  task automatic t_break();
    apb(1'b1, `OFS_CTRL2, 32'h2);
    i_node.hold(1'b1, 5000);
    i_node.hold(1'b0, 6400);
    rdc(`OFS_STATE, {24'h0, `SV_INV});
    rdc(`OFS_CTRL2, 32'h0);
    rdc(`OFS_STATE, 32'h0);
    apb(1'b1, `OFS_CTRL2, 32'h0);
  endtask

  task automatic t_stuck();
    i_node.drv <= 1'b1;
    apb(1'b1, `OFS_DATA, 32'h55);
    repeat (2000) @(posedge pclk);
    chk({31'h0, tx}, 32'h0);
    i_node.gnd <= 1'b1;
    i_node.drv <= 1'b0;
    wait_tx(1'b1, 12000);
    wait_tx(1'b0, 1000);
    rdc(`OFS_STATE, {24'h0, `SV_INV});
    i_node.gnd <= 1'b0;
    drain();
  endtask

  task automatic t_tx();
    int q;
    int t;
    q = 0;
    t = 0;
    i_node.edges = 0;
    apb(1'b1, `OFS_DATA, 32'h55);
    wait_tx(1'b1, 400);
    rdc(`OFS_STATE, {24'h0, `SV_TXE});
    apb(1'b1, `OFS_DATA, 32'h55);
    // Frame over once the line stays passive past END_OF_DATA_SYMBOL length
    while (q < 6400 && t < 80000)
    begin
      @(posedge pclk);
      q = (tx === 1'b1) ? 0 : q + 1;
      t++;
    end
    chk(32'(i_node.edges), 32'h0000000D);
  endtask

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    repeat (6400) @(posedge pclk);
    t_rx_good();
    t_rx_crc();
    t_noise();
    t_break();
    t_stuck();
    t_tx();
    report_and_stop();
  end

  initial
  begin
    repeat (110000) @(posedge pclk);
    errors++;
    report_and_stop();
  end
endmodule
